// ### design/vcsc_ctrl.sv
`default_nettype none
module vcsc_ctrl
   import vcsc_pkg::*;
#(
   parameter int unsigned SAMPLE_DIV_P = vcsc_pkg::SAMPLE_DIV,
   parameter int unsigned STEP_DIV_P   = vcsc_pkg::STEP_DIV
)(
   // Clock and reset
   input  wire logic                       i_clk,
   input  wire logic                       i_rstn,
   // Mode and code pins
   input  wire vcsc_pkg::vcsc_mode_t       i_mode,
   input  wire logic [vcsc_pkg::CODE_W-1:0] i_code,
   // DAC and status
   output var  vcsc_pkg::vcsc_dac_t        o_dac,
   output logic [vcsc_pkg::CODE_W-1:0]     o_target,
   output logic                            o_code_valid,
   output logic                            o_ss_inhibit
);
   import vcsc_pkg::*;

   // ==========================================================
   // Mode and code decoding
   // ==========================================================
   // True in the two stepping modes
   function automatic logic f_is_slew(input vcsc_mode_t m);
      f_is_slew = (m == VCSC_MODE_SLEW_5B) || (m == VCSC_MODE_SLEW_6B);
   endfunction

   // True for the no-load code, which only counts in 5-bit stepping mode
   function automatic logic f_no_load(input vcsc_mode_t m,
                                      input logic [CODE_W-1:0] c);
      f_no_load = (m == VCSC_MODE_SLEW_5B) && (c[4:0] == NO_LOAD_5B);
   endfunction

   // ==========================================================
   // Tick generators
   // ==========================================================
   logic [15:0] samp_cnt_r;
   logic [15:0] step_cnt_r;
   wire         samp_tick = (samp_cnt_r == 16'(SAMPLE_DIV_P - 1));
   wire         step_tick = (step_cnt_r == 16'(STEP_DIV_P - 1));

   // Free-running dividers
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         samp_cnt_r <= 16'h0000;
         step_cnt_r <= 16'h0000;
      end
      else
      begin
         samp_cnt_r <= samp_tick ? 16'h0000 : samp_cnt_r + 16'h0001;
         step_cnt_r <= step_tick ? 16'h0000 : step_cnt_r + 16'h0001;
      end
   end

   // ==========================================================
   // Qualification
   // ==========================================================
   logic [CODE_W-1:0] cand_r;
   logic [1:0]        same_r;
   wire               is_slew  = f_is_slew(i_mode);
   wire               no_load  = f_no_load(i_mode, i_code);
   wire               cand_eq  = (i_code == cand_r);
   wire               new_code = (i_code != o_target);
   wire               qual     = samp_tick && cand_eq && new_code &&
                                 (same_r == 2'(QUAL_COUNT - 1));

   // Sample pins and count matching reads
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         cand_r <= DAC_RESET;
         same_r <= 2'h0;
      end
      else if (samp_tick)
      begin
         cand_r <= i_code;
         if (!cand_eq)
            same_r <= 2'h1;
         else if (same_r != 2'(QUAL_COUNT - 1))
            same_r <= same_r + 2'h1;
      end
   end

   // ==========================================================
   // Target and DAC
   // ==========================================================
   wire dac_up = o_dac.level < o_target;
   wire dac_dn = o_dac.level > o_target;
   logic [CODE_W-1:0] lvl_nxt;

   // Next DAC level
   always_comb
   begin
      lvl_nxt = o_dac.level;
      if (qual && !is_slew)
         lvl_nxt = i_code;
      else if (is_slew && step_tick && dac_up)
         lvl_nxt = o_dac.level + 8'h01;
      else if (is_slew && step_tick && dac_dn)
         lvl_nxt = o_dac.level - 8'h01;
      else if (!is_slew)
         lvl_nxt = o_target;
   end

   // Registered outputs
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_target     <= DAC_RESET;
         o_dac        <= '{level: DAC_RESET, busy: 1'b0};
         o_code_valid <= 1'b0;
         o_ss_inhibit <= 1'b0;
      end
      else
      begin
         if (qual)
            o_target <= i_code;
         o_dac.level  <= lvl_nxt;
         o_dac.busy   <= is_slew && (lvl_nxt != (qual ? i_code : o_target));
         o_code_valid <= qual;
         if (samp_tick)
            o_ss_inhibit <= no_load;
      end
   end

   // ==========================================================
   // Assertions
   // ==========================================================
   // Three matching reads of a new code
   sequence s_three_same;
      samp_tick && cand_eq && new_code && same_r == 2'h2;
   endsequence

   // Valid pulse lasts exactly one cycle
   sequence s_valid_pulse;
      o_code_valid ##1 !o_code_valid;
   endsequence

   // One step toward the target on a stepping tick
   sequence s_step_up;
      is_slew && step_tick && !qual && dac_up;
   endsequence

   sequence s_step_down;
      is_slew && step_tick && !qual && dac_dn;
   endsequence

   // Qualification and refusal
   qual_update_tgt_a : assert property (@(posedge i_clk) disable iff (!i_rstn)
      s_three_same |=> o_target == $past(i_code))
      else $error("Qualified code not loaded");
   valid_pulse_a : assert property (@(posedge i_clk) disable iff (!i_rstn)
      qual |=> s_valid_pulse)
      else $error("Valid pulse not one cycle");
   same_code_a : assert property (@(posedge i_clk) disable iff (!i_rstn)
      (samp_tick && !new_code) |=> !o_code_valid)
      else $error("Current code qualified again");
   short_code_a : assert property (@(posedge i_clk) disable iff (!i_rstn)
      (samp_tick && !cand_eq) |=> !o_code_valid)
      else $error("Changed code qualified too early");
   sample_only_tick_a : assert property (@(posedge i_clk) disable iff (!i_rstn)
      !samp_tick |=> $stable(cand_r))
      else $error("Sample taken off tick");

   // Direct loading and mode choice
   direct_load_dac_a : assert property (@(posedge i_clk) disable iff (!i_rstn)
      (qual && !is_slew) |=> o_dac.level == $past(i_code))
      else $error("Direct mode did not load DAC");
   mode_select_a : assert property (@(posedge i_clk) disable iff (!i_rstn)
      (!is_slew && $past(!is_slew) && !qual) |=> o_dac.level == $past(o_target))
      else $error("Direct mode DAC differs from target");
   direct_idle_a : assert property (@(posedge i_clk) disable iff (!i_rstn)
      !is_slew |=> !o_dac.busy)
      else $error("Busy shown in direct mode");

   // Stepping
   slew_one_step_a : assert property (@(posedge i_clk) disable iff (!i_rstn)
      (is_slew && $past(is_slew) && !$past(qual))
         |-> (o_dac.level - $past(o_dac.level) <= 8'h01 ||
              $past(o_dac.level) - o_dac.level <= 8'h01))
      else $error("Slew moved more than one step");
   slew_only_tick_a : assert property (@(posedge i_clk) disable iff (!i_rstn)
      (is_slew && !step_tick && !qual) |=> $stable(o_dac.level))
      else $error("Slew moved off a step tick");
   slew_stop_eq_a : assert property (@(posedge i_clk) disable iff (!i_rstn)
      (is_slew && o_dac.level == o_target && !qual) |=> $stable(o_dac.level))
      else $error("Slew moved past target");
   step_up_a : assert property (@(posedge i_clk) disable iff (!i_rstn)
      s_step_up |=> o_dac.level == $past(o_dac.level) + 8'h01)
      else $error("Slew did not step up");
   step_down_a : assert property (@(posedge i_clk) disable iff (!i_rstn)
      s_step_down |=> o_dac.level == $past(o_dac.level) - 8'h01)
      else $error("Slew did not step down");
   slew_jump_ok_a : assert property (@(posedge i_clk) disable iff (!i_rstn)
      (qual && is_slew) |=> o_target == $past(i_code))
      else $error("Jump not accepted in slew mode");

   // No-load inhibit
   no_load_inh_a : assert property (@(posedge i_clk) disable iff (!i_rstn)
      (samp_tick && i_mode == VCSC_MODE_SLEW_5B && i_code[4:0] == 5'h1F)
         |=> o_ss_inhibit)
      else $error("No-load code did not inhibit");
   inhibit_clear_a : assert property (@(posedge i_clk) disable iff (!i_rstn)
      (samp_tick && !no_load) |=> !o_ss_inhibit)
      else $error("Inhibit held without no-load code");
endmodule
`default_nettype wire

// ### design/vcsc_pkg.sv
`default_nettype none
package vcsc_pkg;
   // ==========================================================
   // Widths and modes
   // ==========================================================
   localparam int unsigned CODE_W = 8;
   typedef enum logic [1:0] {
      VCSC_MODE_DIRECT_A,   // First vendor, table A
      VCSC_MODE_DIRECT_B,   // First vendor, table B
      VCSC_MODE_SLEW_5B,    // Second vendor, 5-bit table
      VCSC_MODE_SLEW_6B     // Second vendor, 6-bit table
   } vcsc_mode_t;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int unsigned CLK_HZ      = 250_000_000;
   localparam int unsigned SAMPLE_HZ   = 3_000_000;
   localparam int unsigned STEP_HZ     = 330_000;
   // Both intervals round down
   localparam int unsigned SAMPLE_DIV  = CLK_HZ / SAMPLE_HZ;
   localparam int unsigned STEP_DIV    = CLK_HZ / STEP_HZ;
   localparam int unsigned QUAL_COUNT  = 3;
   localparam logic [4:0]  NO_LOAD_5B  = 5'h1F;
   localparam logic [CODE_W-1:0] DAC_RESET = 8'h00;

   // DAC output bundle
   typedef struct packed {
      logic [CODE_W-1:0] level;
      logic              busy;
   } vcsc_dac_t;
endpackage
`default_nettype wire

// ### testbench/vcsc_cpu_model.sv
`default_nettype none
module vcsc_cpu_model #(
   parameter int unsigned GAP = 24
)(
   input  wire logic       i_clk,
   output logic [7:0]      o_code
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned since_chg = 0;
   initial o_code = 8'h00;
   // Count cycles since the code last moved
   always @(posedge i_clk) since_chg <= since_chg + 1;
   // Keep the change spacing unless told to glitch, then move off the edge
   task automatic put(input logic [7:0] c, input bit early);
      while (!early && since_chg < GAP) @(posedge i_clk);
      @(negedge i_clk);
      o_code = c;
      since_chg = 0;
   endtask
endmodule
`default_nettype wire

// ### testbench/tb_vcsc_ctrl.sv
`default_nettype none
module tb_vcsc_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   import vcsc_pkg::*;
   logic i_clk = 0, i_rstn = 0, o_code_valid, o_ss_inhibit;
   vcsc_mode_t i_mode = VCSC_MODE_DIRECT_A;
   logic [7:0] i_code, o_target;
   vcsc_dac_t o_dac;
   int error_cnt = 0, n_compared = 0, k;
   vcsc_ctrl #(.SAMPLE_DIV_P(4), .STEP_DIV_P(10)) u_vcsc_ctrl (.i_clk(i_clk),
      .i_rstn(i_rstn), .i_mode(i_mode), .i_code(i_code), .o_dac(o_dac),
      .o_target(o_target), .o_code_valid(o_code_valid), .o_ss_inhibit(o_ss_inhibit));
   vcsc_cpu_model u_vcsc_cpu_model (.i_clk(i_clk), .o_code(i_code));
   // Clock
   initial forever #2 i_clk = ~i_clk;
   // Compare and report
   task automatic check(string what, logic [8:0] exp, logic [8:0] got);
      n_compared++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Wait for a qualified code, bounded
   task automatic qual(logic [7:0] c);
      k = 0;
      while (o_code_valid !== 1'b1 && k < 40) @(negedge i_clk) k++;
      check("valid", 1, o_code_valid);
      check("target", c, o_target);
      @(negedge i_clk);
      check("pulse", 0, o_code_valid);
   endtask
   // Wait for the slew to end, bounded
   task automatic settle(logic [7:0] c);
      k = 0;
      while (o_dac.busy !== 1'b0 && k < 300) @(negedge i_clk) k++;
      check("level", c, o_dac.level);
   endtask
   task automatic give_verdict;
      if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Watchdog
   initial
   begin
      #20000;
      error_cnt++;
      give_verdict;
   end
   // Direct modes, one code step per change
   task automatic t_direct;
      u_vcsc_cpu_model.put(8'h01, 0);
      qual(8'h01);
      check("direct", 8'h01, o_dac.level);
      i_mode = VCSC_MODE_DIRECT_B;
      u_vcsc_cpu_model.put(8'h02, 0);
      qual(8'h02);
      check("direct b", 8'h02, o_dac.level);
      check("idle", 0, o_dac.busy);
   endtask
   // A one-cycle code must not qualify
   task automatic t_glitch;
      u_vcsc_cpu_model.put(8'h03, 0);
      u_vcsc_cpu_model.put(8'h02, 1);
      repeat (40) @(negedge i_clk);
      check("glitch", 8'h02, o_target);
   endtask
   // Stepping up, down and retargeting
   task automatic t_slew;
      i_mode = VCSC_MODE_SLEW_6B;
      u_vcsc_cpu_model.put(8'h09, 0);
      qual(8'h09);
      check("busy", 1, o_dac.busy);
      check("no jump", 1, o_dac.level < 8'h04);
      settle(8'h09);
      check("rate", 1, k >= 58 && k <= 72);
      u_vcsc_cpu_model.put(8'h05, 0);
      qual(8'h05);
      u_vcsc_cpu_model.put(8'h0A, 0);
      check("down", 1, o_dac.level < 8'h09);
      qual(8'h0A);
      settle(8'h0A);
   endtask
   // No-load code inhibits start-up in 5-bit mode only
   task automatic t_no_load;
      i_mode = VCSC_MODE_SLEW_5B;
      u_vcsc_cpu_model.put(8'h1F, 0);
      qual(8'h1F);
      check("no load", 1, o_ss_inhibit);
      i_mode = VCSC_MODE_DIRECT_A;
      repeat (12) @(negedge i_clk);
      check("load ok", 0, o_ss_inhibit);
      check("mirror", 8'h1F, o_dac.level);
   endtask
   // Reset in mid-run clears everything, then the code requalifies
   task automatic t_reset;
      i_rstn = 0;
      @(negedge i_clk);
      check("rst dac", 0, o_dac);
      check("rst target", 0, o_target);
      check("rst valid", 0, o_code_valid);
      check("rst inhibit", 0, o_ss_inhibit);
      i_rstn = 1;
      qual(8'h1F);
      check("rst direct", 8'h1F, o_dac.level);
   endtask
   // Main sequence
   initial
   begin
      repeat (4) @(negedge i_clk);
      check("rst level", 0, o_dac.level);
      i_rstn = 1;
      t_direct;
      t_glitch;
      t_slew;
      t_no_load;
      t_reset;
      give_verdict;
   end
endmodule
`default_nettype wire
